// ### core/cms_pkg.sv
// package: opcodes, cycle counts, flag positions, register addresses and carriers
package cms_pkg;
  localparam logic [7:0] OPC_MUL_R = 8'h84;
  localparam logic [7:0] OPC_MUL_IR = 8'h85;
  localparam logic [7:0] OPC_MUL_IM = 8'h86;
  localparam logic [7:0] OPC_NEXT = 8'h0f;
  localparam logic [7:0] OPC_IDLE = 8'hff;
  localparam logic [7:0] OPC_OR_RR = 8'h42;
  localparam logic [7:0] OPC_OR_RI = 8'h43;
  localparam logic [7:0] OPC_OR_R = 8'h44;
  localparam logic [7:0] OPC_OR_IR = 8'h45;
  localparam logic [7:0] OPC_OR_IM = 8'h46;
  localparam logic [7:0] OPC_POP_R = 8'h50;
  localparam logic [7:0] OPC_POP_IR = 8'h51;
  localparam logic [4:0] CYC_MUL = 5'h16;
  localparam logic [4:0] CYC_NEXT = 5'h0a;
  localparam logic [4:0] CYC_IDLE = 5'h04;
  localparam logic [4:0] CYC_OR_SHORT = 5'h04;
  localparam logic [4:0] CYC_OR_LONG = 5'h06;
  localparam logic [4:0] CYC_POP = 5'h08;
  localparam logic [4:0] CYC_BAD = 5'h04;
  localparam logic [7:0] ADDR_SPH = 8'hd8;
  localparam logic [7:0] ADDR_SPL = 8'hd9;
  localparam logic [7:0] ADDR_WORK_BASE = 8'hc0;
  localparam logic [15:0] IP_STEP = 16'h0002;
  localparam int FLAG_C = 7;
  localparam int FLAG_Z = 6;
  localparam int FLAG_S = 5;
  localparam int FLAG_V = 4;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET = 16'h0000;
  localparam logic [15:0] IP_RESET = 16'h0000;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] APB_FLAGS = 8'h00;
  localparam logic [7:0] APB_SPH = 8'h04;
  localparam logic [7:0] APB_SPL = 8'h08;
  localparam logic [7:0] APB_IP = 8'h0c;
  localparam logic [7:0] APB_PC = 8'h10;
  localparam logic [7:0] APB_STATUS = 8'h14;
  localparam logic [7:0] APB_RF_WINDOW = 8'h18;
  localparam logic [7:0] APB_RF_DATA = 8'h1c;

  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
  } cms_instr_t;

  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] data;
  } cms_rfw_t;
endpackage

// ### core/cms_regfile.sv
// register file memory, registered read data, two write ports
`timescale 1ns/1ps
`default_nettype none
module cms_regfile (
  input wire logic clk,
  input wire logic [7:0] rdAddrA,
  input wire logic [7:0] rdAddrB,
  input wire cms_pkg::cms_rfw_t wrA,
  input wire cms_pkg::cms_rfw_t wrB,
  output logic [7:0] rdDataA,
  output logic [7:0] rdDataB
);
  logic [7:0] mem [0:255];

  // port b wins on a collision; no reset so it maps onto plain ram
  always_ff @(posedge clk) begin
    if (wrA.we) begin
      mem[wrA.addr] <= wrA.data;
    end
    if (wrB.we) begin
      mem[wrB.addr] <= wrB.data;
    end
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end
endmodule
`default_nettype wire

// ### core/cms_apb.sv
// apb slave: decodes and registers one access, zero-wait
`timescale 1ns/1ps
`default_nettype none
module cms_apb (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] rdWord,
  output logic wrStb,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic pready
);
  logic [31:0] prdataD;
  logic errD;
  logic known;

  // known offsets only; others answer with pslverr and zero data
  always_comb begin
    known = (paddr == cms_pkg::APB_FLAGS) || (paddr == cms_pkg::APB_SPH) ||
            (paddr == cms_pkg::APB_SPL) || (paddr == cms_pkg::APB_IP) ||
            (paddr == cms_pkg::APB_PC) || (paddr == cms_pkg::APB_STATUS) ||
            (paddr == cms_pkg::APB_RF_WINDOW) || (paddr == cms_pkg::APB_RF_DATA);
    // write lands only at the edge that completes the access phase
    wrStb = psel && penable && pready && pwrite && known;
    prdataD = (known && !pwrite) ? rdWord : 32'h0;
    errD = !known;
  end

  // answer registered in the setup cycle so the access phase completes at once
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
      pready <= 1'b0;
    end else begin
      prdata <= (psel && !penable) ? prdataD : prdata;
      pslverr <= (psel && !penable) ? errD : 1'b0;
      pready <= psel && !penable;
    end
  end
endmodule
`default_nettype wire

// ### core/cms_exec.sv
// decode/execute core for multiply, threaded next, idle, or and stack pop
// Function
// - multiply even destination register by source, store 16-bit product in pair
// - both multiply operands are unsigned
// - multiply sets carry when product exceeds 255
// - multiply: zero on zero, sign from msb, clear overflow, keep d and h
// - opcodes 84, 85, 86 multiply, three bytes, 22 cycles
// - next loads pc from word at ip, then ip plus 2, flags kept
// - or writes source or destination to destination, source kept
// - or: zero on zero, sign from bit 7, clear overflow, others kept
// - or opcodes 42 to 46 with their byte and cycle counts
// - pop 50/51 loads destination from stack, sp plus one, 8 cycles
`timescale 1ns/1ps
`default_nettype none
module cms_exec (
  input wire logic clk,
  input wire logic resetn,
  input wire cms_pkg::cms_instr_t instr,
  output logic instrReady,
  output logic [15:0] progAddr,
  output logic progRd,
  input wire logic [15:0] progData,
  input wire logic progValid,
  output logic [15:0] pcOut,
  output logic busy,
  output logic badOp,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD1 = 3'b001,
    ST_RD2 = 3'b010,
    ST_CALC = 3'b011,
    ST_FETCH = 3'b100,
    ST_WAIT = 3'b101
  } cms_state_t;

  typedef enum logic [2:0] {
    K_MUL = 3'b000,
    K_OR = 3'b001,
    K_POP = 3'b010,
    K_NEXT = 3'b011,
    K_IDLE = 3'b100,
    K_BAD = 3'b101
  } cms_kind_t;

  cms_state_t state_q, state_d;
  cms_kind_t kind_q, kind_d;
  logic [7:0] op_q, op_d;
  logic [7:0] dstAddr_q, dstAddr_d;
  logic [7:0] srcAddr_q, srcAddr_d;
  logic [7:0] imm_q, imm_d;
  logic [7:0] dstVal_q, dstVal_d;
  logic [4:0] cnt_q, cnt_d;
  logic [7:0] flags_q, flags_d;
  logic [15:0] sp_q, sp_d;
  logic [15:0] ip_q, ip_d;
  logic [15:0] pc_q, pc_d;
  logic progRd_q, progRd_d;
  logic badOp_q, badOp_d;
  logic [7:0] rfWin_q, rfWin_d;
  logic [7:0] rdAddrA, rdAddrB, rdDataA, rdDataB;
  logic busy_q, busy_d;
  logic rdy_q, rdy_d;
  cms_pkg::cms_rfw_t wrA, wrB;
  logic apbWr;
  logic [31:0] rdWord;
  logic [15:0] product;
  logic [7:0] orRes;
  logic [7:0] srcVal;

  // working register r0..r15 maps to a bank at a fixed base
  function automatic logic [7:0] workAddr(input logic [3:0] r);
    workAddr = cms_pkg::ADDR_WORK_BASE | {4'h0, r};
  endfunction

  // zero, sign, cleared overflow; carry handled by caller
  function automatic logic [7:0] logicFlags(input logic [7:0] f, input logic [7:0] msb,
                                             input logic zero);
    logic [7:0] r;
    r = f;
    r[cms_pkg::FLAG_Z] = zero;
    r[cms_pkg::FLAG_S] = msb[7];
    r[cms_pkg::FLAG_V] = 1'b0;
    logicFlags = r;
  endfunction

  cms_regfile uRf (
    .clk(clk),
    .rdAddrA(rdAddrA),
    .rdAddrB(rdAddrB),
    .wrA(wrA),
    .wrB(wrB),
    .rdDataA(rdDataA),
    .rdDataB(rdDataB)
  );

  cms_apb uApb (
    .clk(clk),
    .resetn(resetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .rdWord(rdWord),
    .wrStb(apbWr),
    .prdata(prdata),
    .pslverr(pslverr),
    .pready(pready)
  );

  // unsigned: zero-extended 8x8 gives exactly 16 bits
  assign product = {8'h00, dstVal_q} * {8'h00, srcVal};
  assign orRes = dstVal_q | srcVal;
  assign srcVal = (op_q == cms_pkg::OPC_MUL_IM || op_q == cms_pkg::OPC_OR_IM) ? imm_q : rdDataB;

  always_comb begin
    case (paddr)
      cms_pkg::APB_FLAGS: rdWord = {24'h0, flags_q};
      cms_pkg::APB_SPH: rdWord = {24'h0, sp_q[15:8]};
      cms_pkg::APB_SPL: rdWord = {24'h0, sp_q[7:0]};
      cms_pkg::APB_IP: rdWord = {16'h0, ip_q};
      cms_pkg::APB_PC: rdWord = {16'h0, pc_q};
      cms_pkg::APB_STATUS: rdWord = {24'h0, 5'h0, state_q};
      cms_pkg::APB_RF_WINDOW: rdWord = {24'h0, rfWin_q};
      cms_pkg::APB_RF_DATA: rdWord = {24'h0, rdDataA};
      default: rdWord = 32'h0;
    endcase
  end

  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    op_d = op_q;
    dstAddr_d = dstAddr_q;
    srcAddr_d = srcAddr_q;
    imm_d = imm_q;
    dstVal_d = dstVal_q;
    cnt_d = (cnt_q != 5'h0) ? cnt_q - 5'h1 : 5'h0;
    flags_d = flags_q;
    sp_d = sp_q;
    ip_d = ip_q;
    pc_d = pc_q;
    progRd_d = 1'b0;
    badOp_d = 1'b0;
    rfWin_d = rfWin_q;
    rdAddrA = rfWin_q;
    rdAddrB = srcAddr_q;
    wrA = '0;
    wrB = '0;
    if (apbWr) begin
      case (paddr)
        cms_pkg::APB_FLAGS: flags_d = pwdata[7:0];
        cms_pkg::APB_SPH: sp_d[15:8] = pwdata[7:0];
        cms_pkg::APB_SPL: sp_d[7:0] = pwdata[7:0];
        cms_pkg::APB_IP: ip_d = pwdata[15:0];
        cms_pkg::APB_PC: pc_d = pwdata[15:0];
        cms_pkg::APB_RF_WINDOW: rfWin_d = pwdata[7:0];
        cms_pkg::APB_RF_DATA: wrB = '{we: 1'b1, addr: rfWin_q, data: pwdata[7:0]};
        default: rfWin_d = rfWin_q;
      endcase
    end
    case (state_q)
      ST_IDLE: begin
        if (instr.valid) begin
          op_d = instr.opcode;
          imm_d = instr.byte1;
          state_d = ST_RD1;
          case (instr.opcode)
            cms_pkg::OPC_MUL_R, cms_pkg::OPC_MUL_IR, cms_pkg::OPC_MUL_IM: begin
              kind_d = K_MUL;
              cnt_d = cms_pkg::CYC_MUL - 5'h1;
              srcAddr_d = instr.byte1;
              dstAddr_d = {instr.byte2[7:1], 1'b0};
            end
            cms_pkg::OPC_OR_RR, cms_pkg::OPC_OR_RI: begin
              kind_d = K_OR;
              cnt_d = ((instr.opcode == cms_pkg::OPC_OR_RR) ? cms_pkg::CYC_OR_SHORT
                       : cms_pkg::CYC_OR_LONG) - 5'h1;
              dstAddr_d = workAddr(instr.byte1[7:4]);
              srcAddr_d = workAddr(instr.byte1[3:0]);
            end
            cms_pkg::OPC_OR_R, cms_pkg::OPC_OR_IR: begin
              kind_d = K_OR;
              cnt_d = cms_pkg::CYC_OR_LONG - 5'h1;
              srcAddr_d = instr.byte1;
              dstAddr_d = instr.byte2;
            end
            cms_pkg::OPC_OR_IM: begin
              kind_d = K_OR;
              cnt_d = cms_pkg::CYC_OR_LONG - 5'h1;
              dstAddr_d = instr.byte1;
              imm_d = instr.byte2;
              srcAddr_d = instr.byte1;
            end
            cms_pkg::OPC_POP_R, cms_pkg::OPC_POP_IR: begin
              kind_d = K_POP;
              cnt_d = cms_pkg::CYC_POP - 5'h1;
              dstAddr_d = instr.byte1;
              srcAddr_d = sp_q[7:0];
            end
            cms_pkg::OPC_NEXT: begin
              kind_d = K_NEXT;
              cnt_d = cms_pkg::CYC_NEXT - 5'h1;
              state_d = ST_FETCH;
            end
            cms_pkg::OPC_IDLE: begin
              kind_d = K_IDLE;
              cnt_d = cms_pkg::CYC_IDLE - 5'h1;
              state_d = ST_WAIT;
            end
            default: begin
              kind_d = K_BAD;
              badOp_d = 1'b1;
              cnt_d = cms_pkg::CYC_BAD - 5'h1;
              state_d = ST_WAIT;
            end
          endcase
        end
      end
      ST_RD1: begin
        // indirect forms: first read fetches the pointer, then the operand
        rdAddrA = dstAddr_q;
        rdAddrB = srcAddr_q;
        state_d = ST_RD2;
      end
      ST_RD2: begin
        rdAddrA = dstAddr_q;
        rdAddrB = srcAddr_q;
        if (op_q == cms_pkg::OPC_OR_RI || op_q == cms_pkg::OPC_OR_IR ||
            op_q == cms_pkg::OPC_MUL_IR) begin
          srcAddr_d = (op_q == cms_pkg::OPC_OR_RI) ? rdDataB : rdDataB;
          op_d = (op_q == cms_pkg::OPC_MUL_IR) ? cms_pkg::OPC_MUL_R
               : (op_q == cms_pkg::OPC_OR_RI) ? cms_pkg::OPC_OR_RR : cms_pkg::OPC_OR_R;
          state_d = ST_RD1;
        end else if (op_q == cms_pkg::OPC_POP_IR) begin
          dstAddr_d = rdDataA; // destination is the register that dst points at
          op_d = cms_pkg::OPC_POP_R;
          state_d = ST_RD1;
        end else begin
          dstVal_d = rdDataA;
          state_d = ST_CALC;
        end
      end
      ST_CALC: begin
        rdAddrB = srcAddr_q;
        // short forms have no cycles left to wait, so they finish here
        state_d = (cnt_q <= 5'h1) ? ST_IDLE : ST_WAIT;
        case (kind_q)
          K_MUL: begin
            wrA = '{we: 1'b1, addr: dstAddr_q, data: product[15:8]};
            wrB = '{we: 1'b1, addr: dstAddr_q | 8'h01, data: product[7:0]};
            flags_d = logicFlags(flags_q, product[15:8], product == 16'h0);
            flags_d[cms_pkg::FLAG_C] = (product > 16'h00ff);
          end
          K_OR: begin
            wrA = '{we: 1'b1, addr: dstAddr_q, data: orRes};
            flags_d = logicFlags(flags_q, orRes, orRes == 8'h0);
          end
          K_POP: begin
            wrA = '{we: 1'b1, addr: dstAddr_q, data: rdDataB};
            sp_d = sp_q + 16'h0001;
          end
          default: flags_d = flags_q;
        endcase
      end
      ST_FETCH: begin
        progRd_d = !progValid;
        if (progValid) begin
          pc_d = progData;
          ip_d = ip_q + cms_pkg::IP_STEP;
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (cnt_q <= 5'h1) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    // registered copies so ready and busy leave the block straight from flops
    busy_d = (state_d != ST_IDLE);
    rdy_d = (state_d == ST_IDLE);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      kind_q <= K_IDLE;
      op_q <= cms_pkg::OPC_IDLE;
      dstAddr_q <= 8'h00;
      srcAddr_q <= 8'h00;
      imm_q <= 8'h00;
      dstVal_q <= 8'h00;
      cnt_q <= 5'h00;
      flags_q <= cms_pkg::FLAGS_RESET;
      sp_q <= cms_pkg::SP_RESET;
      ip_q <= cms_pkg::IP_RESET;
      pc_q <= cms_pkg::PC_RESET;
      progRd_q <= 1'b0;
      badOp_q <= 1'b0;
      rfWin_q <= 8'h00;
      busy_q <= 1'b0;
      rdy_q <= 1'b1;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      op_q <= op_d;
      dstAddr_q <= dstAddr_d;
      srcAddr_q <= srcAddr_d;
      imm_q <= imm_d;
      dstVal_q <= dstVal_d;
      cnt_q <= cnt_d;
      flags_q <= flags_d;
      sp_q <= sp_d;
      ip_q <= ip_d;
      pc_q <= pc_d;
      progRd_q <= progRd_d;
      badOp_q <= badOp_d;
      rfWin_q <= rfWin_d;
      busy_q <= busy_d;
      rdy_q <= rdy_d;
    end
  end

  assign progAddr = ip_q;
  assign progRd = progRd_q;
  assign pcOut = pc_q;
  assign busy = busy_q;
  assign instrReady = rdy_q;
  assign badOp = badOp_q;
endmodule
`default_nettype wire

// ### sim/cms_exec_chk.sv
// checker: timing and handshake assertions on the exec core ports
`timescale 1ns/1ps
`default_nettype none
module cms_exec_chk (
  input wire logic clk,
  input wire logic resetn,
  input wire cms_pkg::cms_instr_t instr,
  input wire logic instrReady,
  input wire logic [15:0] progAddr,
  input wire logic progRd,
  input wire logic [15:0] progData,
  input wire logic progValid,
  input wire logic [15:0] pcOut,
  input wire logic busy,
  input wire logic badOp,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic [7:0] op;
  assign take = instr.valid && instrReady;
  assign op = instr.opcode;
  a_ready_busy: assert property (instrReady == !busy) else $error("ready and busy disagree");
  a_mul_len: assert property (take && op inside {8'h84, 8'h85, 8'h86} |=> busy ##20 busy ##1 !busy)
    else $error("multiply length wrong");
  a_short_len: assert property (take && op inside {8'hff, 8'h42} |=> busy ##2 busy ##1 !busy)
    else $error("short op length wrong");
  a_or_len: assert property (take && op inside {[8'h43:8'h46]} |=> busy ##4 busy ##1 !busy)
    else $error("or length wrong");
  a_pop_len: assert property (take && op inside {8'h50, 8'h51} |=> busy ##6 busy ##1 !busy)
    else $error("pop length wrong");
  a_next_fetch: assert property (take && op == 8'h0f |-> ##[1:3] progRd) else $error("no fetch");
  a_next_load: assert property (progRd && progValid |=>
    pcOut == $past(progData) && progAddr == $past(progAddr) + 16'h0002)
    else $error("pc or pointer not loaded");
  a_idle_pc: assert property (take && op == 8'hff |=> $stable(pcOut)[*4])
    else $error("idle moved pc");
  a_bad_flag: assert property (take && !(op inside {8'h84, 8'h85, 8'h86, 8'h0f, 8'hff,
    [8'h42:8'h46], 8'h50, 8'h51}) |=> badOp) else $error("bad opcode not flagged");
  a_bad_pulse: assert property (badOp |=> !badOp) else $error("bad flag too long");
  a_apb_answer: assert property (psel && !penable |=> pready) else $error("no ready");
  a_apb_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
endmodule
bind cms_exec cms_exec_chk u_chk (.clk(clk), .resetn(resetn), .instr(instr),
  .instrReady(instrReady), .progAddr(progAddr), .progRd(progRd), .progData(progData),
  .progValid(progValid), .pcOut(pcOut), .busy(busy), .badOp(badOp), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ### sim/cms_prog_mem.sv
// program memory model: answers a word read after lag cycles
`timescale 1ns/1ps
`default_nettype none
module cms_prog_mem (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] progAddr,
  input wire logic progRd,
  input wire logic [1:0] lag,
  output logic [15:0] progData,
  output logic progValid
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 2'h0;
      progValid <= 1'b0;
      progData <= 16'h0;
    end else begin
      progValid <= 1'b0;
      // no word on the bus: toggle so a stale value never looks valid
      progData <= ~progData;
      if (progRd && !progValid) begin
        cnt_q <= (cnt_q == lag) ? 2'h0 : cnt_q + 2'h1;
        if (cnt_q == lag) begin
          progValid <= 1'b1;
          progData <= {progAddr[7:0] ^ 8'h3c, progAddr[15:8] + 8'h01};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ### sim/tb.sv
// testbench for the exec core
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, resetn, instrReady, progRd, progValid, busy, badOp;
  logic psel, penable, pwrite, pready, pslverr, err;
  cms_pkg::cms_instr_t instr;
  logic [15:0] progAddr, progData, pcOut, p, ip;
  logic [7:0] paddr, a, b, f, sa, sp;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] lag;
  int fail_count, n_checks, m;
  cms_exec DUT (.clk(clk), .resetn(resetn), .instr(instr), .instrReady(instrReady),
    .progAddr(progAddr), .progRd(progRd), .progData(progData), .progValid(progValid),
    .pcOut(pcOut), .busy(busy), .badOp(badOp), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  cms_prog_mem u_mem (.clk(clk), .resetn(resetn), .progAddr(progAddr), .progRd(progRd),
    .lag(lag), .progData(progData), .progValid(progValid));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [7:0] flx(input logic [15:0] r, input logic [7:0] fo, input logic mul);
    return {mul ? r > 16'd255 : fo[7], r == 16'h0, mul ? r[15] : r[7], 1'b0, fo[3:0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rfw(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, 8'h18, {24'h0, ad});
    apb(1'b1, 8'h1c, {24'h0, d});
  endtask
  task automatic rfr(input logic [7:0] ad);
    apb(1'b1, 8'h18, {24'h0, ad});
    apb(1'b0, 8'h1c, 32'h0);
  endtask
  task automatic exec(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2);
    @(posedge clk);
    while (!instrReady) @(posedge clk);
    instr <= {1'b1, op, b1, b2};
    @(posedge clk);
    instr.valid <= 1'b0;
    @(posedge clk);
    while (!instrReady) @(posedge clk);
  endtask
  initial begin
    #200000;
    fail_count++;
    end_sim;
  end
  initial begin
    resetn = 1'b0;
    instr = '0;
    {psel, penable, pwrite, paddr, pwdata, lag} = '0;
    fail_count = 0;
    n_checks = 0;
    void'($urandom(66));
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 8'(k * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset done");
    for (int k = 0; k < 12; k++) begin
      m = k % 3;
      a = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
      b = (k == 0) ? 8'hff : 8'($urandom);
      f = 8'($urandom);
      rfw(8'h20, b);
      rfw(8'h30, a);
      rfw(8'h31, 8'h30);
      apb(1'b1, 8'h00, {24'h0, f});
      exec(8'h84 + 8'(m), (m == 0) ? 8'h30 : (m == 1) ? 8'h31 : a, 8'h20);
      p = 16'(a) * 16'(b);
      rfr(8'h20);
      chk(rd, {24'h0, p[15:8]});
      rfr(8'h21);
      chk(rd, {24'h0, p[7:0]});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, flx(p, f, 1'b1)});
    end
    $display("test multiply done");
    for (int k = 0; k < 10; k++) begin
      m = k % 5;
      a = (k == 0) ? 8'h00 : 8'($urandom);
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($urandom);
      f = 8'($urandom);
      sp = (m < 2) ? 8'hc2 : 8'h20;
      sa = (m == 0) ? 8'hc5 : 8'h30;
      rfw(sp, a);
      rfw(8'h30, b);
      rfw(8'h31, 8'h30);
      rfw(8'hc5, (m == 0) ? b : 8'h30);
      apb(1'b1, 8'h00, {24'h0, f});
      case (m)
        0, 1: exec(8'h42 + 8'(m), 8'h25, 8'h00);
        2: exec(8'h44, 8'h30, 8'h20);
        3: exec(8'h45, 8'h31, 8'h20);
        default: exec(8'h46, 8'h20, b);
      endcase
      rfr(sp);
      chk(rd, {24'h0, a | b});
      rfr(sa);
      chk(rd, {24'h0, b});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, flx({8'h0, a | b}, f, 1'b0)});
    end
    $display("test or done");
    for (int k = 0; k < 6; k++) begin
      sp = (k == 0) ? 8'hff : 8'h40 + 8'($urandom_range(63));
      a = 8'($urandom);
      f = 8'($urandom);
      rfw(sp, a);
      rfw(8'h31, 8'h20);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h08, {24'h0, sp});
      apb(1'b1, 8'h00, {24'h0, f});
      exec(8'h50 + 8'(k % 2), (k % 2 == 1) ? 8'h31 : 8'h20, 8'h00);
      rfr(8'h20);
      chk(rd, {24'h0, a});
      p = {8'h0, sp} + 16'h1;
      apb(1'b0, 8'h04, 32'h0);
      chk(rd, {24'h0, p[15:8]});
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {24'h0, p[7:0]});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, f});
    end
    $display("test pop done");
    for (int k = 0; k < 4; k++) begin
      ip = {8'($urandom), 7'($urandom), 1'b0};
      f = 8'($urandom);
      lag <= 2'(k);
      apb(1'b1, 8'h0c, {16'h0, ip});
      apb(1'b1, 8'h00, {24'h0, f});
      exec(8'h0f, 8'h00, 8'h00);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd, {16'h0, ip[7:0] ^ 8'h3c, ip[15:8] + 8'h01});
      chk({16'h0, pcOut}, {16'h0, ip[7:0] ^ 8'h3c, ip[15:8] + 8'h01});
      chk({16'h0, progAddr}, {16'h0, ip + 16'h2});
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, {16'h0, ip + 16'h2});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, {24'h0, f});
    end
    $display("test next done");
    exec(8'hff, 8'h00, 8'h00);
    exec(8'h00, 8'h00, 8'h00);
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, {16'h0, ip + 16'h2});
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, {24'h0, f});
    $display("test idle done");
    end_sim;
  end
endmodule
`default_nettype wire
